// ---- rtl/ptpo_map.svh ----
// Register map, field positions and reset values of the insertion-control output stage.
// Assumes a 32-bit classic Wishbone slave with byte addresses.
`ifndef PTPO_MAP_SVH
`define PTPO_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define PTPO_ADR_CTRL 8'h00
`define PTPO_ADR_BIAS 8'h04
`define PTPO_ADR_STATUS 8'h08
`define PTPO_ADR_FRAMES 8'h0C
`define PTPO_ADR_MISSES 8'h10

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PTPO_CTRL_ENABLE_BIT 0
`define PTPO_ST_MODE_LSB 0
`define PTPO_ST_PENDING_BIT 2
`define PTPO_ST_OVERRUN_BIT 3
`define PTPO_ST_MISS_BIT 4
`define PTPO_ST_INSERT_BIT 5
`define PTPO_ST_RESID_BIT 6
`define PTPO_ST_PERMIT_BIT 7

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PTPO_CTRL_ENABLE_RST 1'h1
`define PTPO_BIAS_RST 16'h0000
`define PTPO_COUNT_RST 32'h0000_0000

`endif

// ---- rtl/ptpo_pkg.sv ----
// Types shared by the insertion-control output stage and its decision holder.
// Assumes nothing beyond a SystemVerilog compiler.
package ptpo_pkg;

  // ----------------------------------------------------------------------
  // Clock mode as carried on the two-bit mode input
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PTPO_ORDINARY,
    PTPO_BOUNDARY,
    PTPO_E2E_TC,
    PTPO_P2P_TC
  } ptpo_mode_e;

  // ----------------------------------------------------------------------
  // One decoded per-frame insertion decision
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic checksumZero;
    logic checksumCorrect;
    logic tsFormat;
    logic tsInsert;
    logic residence;
    logic [15:0] offTimestamp;
    logic [15:0] offCorrection;
    logic [15:0] offChecksum;
    logic [15:0] offChecksumCorr;
  } ptpo_decision_s;

endpackage : ptpo_pkg

// ---- rtl/ptpo_hold_if.sv ----
// Link between the output stage and its pending-decision holder.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface ptpo_hold_if;
  import ptpo_pkg::*;

  logic load;
  ptpo_decision_s loadData;
  logic take;
  logic pending;
  logic overrun;
  ptpo_decision_s data;

  modport holder (input load, input loadData, input take,
                  output pending, output overrun, output data);
  modport user (output load, output loadData, output take,
                input pending, input overrun, input data);
endinterface : ptpo_hold_if

// ---- rtl/ptpo_hold.sv ----
// Holder of the next frame's insertion decision until that frame starts.
// Assumes load and take are single-cycle strobes qualified by the clock enable.
`timescale 1ns/1ps
module ptpo_hold
  import ptpo_pkg::*;
(
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Holder side of the link
  ptpo_hold_if.holder hold
);

  logic pending;
  logic next_pending;
  ptpo_decision_s data;
  ptpo_decision_s next_data;

  // Next state: a new load replaces the slot, a take empties it
  always_comb begin
    next_pending = pending;
    next_data = data;
    if (hold.load) begin
      next_pending = 1'b1;
      next_data = hold.loadData;
    end else if (hold.take) begin
      next_pending = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pending <= 1'b0;
      data <= '0;
    end else if (ce) begin
      pending <= next_pending;
      data <= next_data;
    end
  end

  // Outputs; overrun flags a decision replaced before its frame began
  assign hold.pending = pending;
  assign hold.data = data;
  assign hold.overrun = hold.load & pending & ~hold.take;

endmodule : ptpo_hold

// ---- rtl/ptpo_out.sv ----
// Insertion-control output stage of a PTP frame classifier, Wishbone register slave.
// Assumes the decoder presents each decision before the first beat of its frame,
// and the frame data is delayed one cycle downstream like frmSop/frmValid/frmEop.
//
// Behaviour
// - Every insertion command output except residence-update is aligned with its frame's first beat.
// - Every 16-bit offset output is aligned with its frame's first beat.
// - Checksum-zero command is high only when checksum must be overwritten.
// - Checksum-correct command asks repair via the word at the corrector offset.
// - One bit gives the timestamp format of the frame receiving a timestamp.
// - Timestamp-insert command is high exactly for frames needing a timestamp.
// - Residence-update command asks to add residence time to correction field.
// - A 16-bit offset locates the timestamp field in the frame.
// - A 16-bit offset locates the correction field in the frame.
// - A 16-bit offset locates the checksum field in the frame.
// - A 16-bit offset locates the checksum corrector word in the frame.
// - Residence-update output is cleared at the next enabled clock edge once its permission input is low.
// - Clock mode codes 00,01,10,11 mean ordinary, boundary, E2E TC, P2P TC.
`timescale 1ns/1ps
`include "ptpo_map.svh"
module ptpo_out
  import ptpo_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Decision from the packet decoder
  input wire logic decValid,
  input wire logic decChecksumZero,
  input wire logic decChecksumCorrect,
  input wire logic decTsFormat,
  input wire logic decTsInsert,
  input wire logic decResidence,
  input wire logic [15:0] decOffTimestamp,
  input wire logic [15:0] decOffCorrection,
  input wire logic [15:0] decOffChecksum,
  input wire logic [15:0] decOffChecksumCorr,
  // Frame markers in and delayed out
  input wire logic frmSopIn,
  input wire logic frmValidIn,
  input wire logic frmEopIn,
  output logic frmSop,
  output logic frmValid,
  output logic frmEop,
  // Mode and residence permission
  input wire logic [1:0] clockMode,
  input wire logic residPermit,
  // Insertion commands
  output logic cmdChecksumZero,
  output logic cmdChecksumCorrect,
  output logic cmdTsFormat,
  output logic cmdTsInsert,
  output logic cmdResidenceUpdate,
  // Field locations
  output logic [15:0] offTimestamp,
  output logic [15:0] offCorrection,
  output logic [15:0] offChecksum,
  output logic [15:0] offChecksumCorr
);

  // ----------------------------------------------------------------------
  // Decision holder
  // ----------------------------------------------------------------------
  ptpo_hold_if holdLink ();

  ptpo_hold u_hold (
    .core_clk(core_clk),
    .nrst(nrst),
    .ce(ce),
    .hold(holdLink.holder)
  );

  logic firstBeat;
  logic accept;
  logic tcMode;
  ptpo_mode_e mode;
  logic enable;
  logic [15:0] bias;

  // Frame start and decision acceptance
  assign firstBeat = frmSopIn & frmValidIn;
  assign accept = firstBeat & holdLink.pending & enable;
  assign holdLink.take = firstBeat;
  assign holdLink.load = decValid;
  assign holdLink.loadData = '{checksumZero: decChecksumZero,
                               checksumCorrect: decChecksumCorrect,
                               tsFormat: decTsFormat,
                               tsInsert: decTsInsert,
                               residence: decResidence,
                               offTimestamp: decOffTimestamp,
                               offCorrection: decOffCorrection,
                               offChecksum: decOffChecksum,
                               offChecksumCorr: decOffChecksumCorr};

  // Mode decode; residence time only applies to transparent clocks
  assign mode = ptpo_mode_e'(clockMode);
  assign tcMode = (mode == PTPO_E2E_TC) || (mode == PTPO_P2P_TC);

  // ----------------------------------------------------------------------
  // Command and offset outputs
  // ----------------------------------------------------------------------
  ptpo_decision_s cmd;
  ptpo_decision_s next_cmd;
  logic next_frmSop;
  logic next_frmValid;
  logic next_frmEop;

  // Load at the first beat, hold otherwise; permission low clears residence
  always_comb begin
    next_cmd = cmd;
    next_frmSop = firstBeat;
    next_frmValid = frmValidIn;
    next_frmEop = frmEopIn & frmValidIn;
    if (firstBeat) begin
      next_cmd = '0;
      if (accept) begin
        next_cmd.checksumZero = holdLink.data.checksumZero;
        next_cmd.checksumCorrect = holdLink.data.checksumCorrect;
        next_cmd.tsFormat = holdLink.data.tsFormat;
        next_cmd.tsInsert = holdLink.data.tsInsert;
        next_cmd.residence = holdLink.data.residence & tcMode;
        next_cmd.offTimestamp = 16'(holdLink.data.offTimestamp + bias);
        next_cmd.offCorrection = 16'(holdLink.data.offCorrection + bias);
        next_cmd.offChecksum = 16'(holdLink.data.offChecksum + bias);
        next_cmd.offChecksumCorr = 16'(holdLink.data.offChecksumCorr + bias);
      end
    end
    if (!residPermit) begin
      next_cmd.residence = 1'b0;
    end
  end

  // Output registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cmd <= '0;
      frmSop <= 1'b0;
      frmValid <= 1'b0;
      frmEop <= 1'b0;
    end else if (ce) begin
      cmd <= next_cmd;
      frmSop <= next_frmSop;
      frmValid <= next_frmValid;
      frmEop <= next_frmEop;
    end
  end

  // Outputs straight from the command register
  assign cmdChecksumZero = cmd.checksumZero;
  assign cmdChecksumCorrect = cmd.checksumCorrect;
  assign cmdTsFormat = cmd.tsFormat;
  assign cmdTsInsert = cmd.tsInsert;
  assign cmdResidenceUpdate = cmd.residence;
  assign offTimestamp = cmd.offTimestamp;
  assign offCorrection = cmd.offCorrection;
  assign offChecksum = cmd.offChecksum;
  assign offChecksumCorr = cmd.offChecksumCorr;

  // ----------------------------------------------------------------------
  // Wishbone registers
  // ----------------------------------------------------------------------
  logic next_enable;
  logic [15:0] next_bias;
  logic overrun;
  logic next_overrun;
  logic miss;
  logic next_miss;
  logic [31:0] frames;
  logic [31:0] next_frames;
  logic [31:0] misses;
  logic [31:0] next_misses;
  logic next_ack;
  logic [31:0] next_dat;
  logic access;
  logic wr;
  logic [31:0] status;
  logic missEvent;

  assign access = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = access & wb_we_i;
  assign missEvent = firstBeat & ~holdLink.pending;
  assign status = {24'h00_0000, residPermit, cmd.residence, cmd.tsInsert, miss, overrun,
                   holdLink.pending, clockMode};

  // Register writes, sticky flags (event wins over clear), read mux
  always_comb begin
    next_enable = enable;
    next_bias = bias;
    next_overrun = overrun;
    next_miss = miss;
    next_frames = frames + {31'h0000_0000, accept};
    next_misses = misses + {31'h0000_0000, missEvent};
    next_ack = access;
    next_dat = 32'h0000_0000;
    if (wr && wb_adr_i == `PTPO_ADR_CTRL && wb_sel_i[0]) begin
      next_enable = wb_dat_i[`PTPO_CTRL_ENABLE_BIT];
    end
    if (wr && wb_adr_i == `PTPO_ADR_BIAS) begin
      if (wb_sel_i[0]) begin
        next_bias[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1]) begin
        next_bias[15:8] = wb_dat_i[15:8];
      end
    end
    if (wr && wb_adr_i == `PTPO_ADR_STATUS && wb_sel_i[0]) begin
      if (wb_dat_i[`PTPO_ST_OVERRUN_BIT]) begin
        next_overrun = 1'b0;
      end
      if (wb_dat_i[`PTPO_ST_MISS_BIT]) begin
        next_miss = 1'b0;
      end
    end
    if (holdLink.overrun) begin
      next_overrun = 1'b1;
    end
    if (missEvent) begin
      next_miss = 1'b1;
    end
    if (access && !wb_we_i) begin
      case (wb_adr_i)
        `PTPO_ADR_CTRL: next_dat = {31'h0000_0000, enable};
        `PTPO_ADR_BIAS: next_dat = {16'h0000, bias};
        `PTPO_ADR_STATUS: next_dat = status;
        `PTPO_ADR_FRAMES: next_dat = frames;
        `PTPO_ADR_MISSES: next_dat = misses;
        default: next_dat = 32'h0000_0000;
      endcase
    end
  end

  // Register state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      enable <= `PTPO_CTRL_ENABLE_RST;
      bias <= `PTPO_BIAS_RST;
      overrun <= 1'b0;
      miss <= 1'b0;
      frames <= `PTPO_COUNT_RST;
      misses <= `PTPO_COUNT_RST;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (ce) begin
      enable <= next_enable;
      bias <= next_bias;
      overrun <= next_overrun;
      miss <= next_miss;
      frames <= next_frames;
      misses <= next_misses;
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence sTakeFrame;
    ce && accept;
  endsequence

  sequence sBusReq;
    ce && wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence

  a_sop_align: assert property (ce && firstBeat |=> frmSop)
    else $error("frame start marker not delayed by one cycle");

  a_zero_follow: assert property (sTakeFrame |=>
      cmdChecksumZero == $past(holdLink.data.checksumZero) &&
      cmdChecksumCorrect == $past(holdLink.data.checksumCorrect))
    else $error("checksum commands do not follow accepted decision");

  a_insert_follow: assert property (sTakeFrame |=>
      cmdTsInsert == $past(holdLink.data.tsInsert) && cmdTsFormat == $past(holdLink.data.tsFormat))
    else $error("timestamp commands do not follow accepted decision");

  a_offset_bias: assert property (sTakeFrame |=>
      offTimestamp == 16'($past(holdLink.data.offTimestamp) + $past(bias)) &&
      offChecksumCorr == 16'($past(holdLink.data.offChecksumCorr) + $past(bias)))
    else $error("offset outputs not decision plus bias");

  a_miss_clear: assert property (ce && missEvent |=> !cmdTsInsert && !cmdChecksumZero)
    else $error("commands raised for frame without decision");

  a_resid_block: assert property (ce && !residPermit |=> !cmdResidenceUpdate)
    else $error("residence update while permission low");

  a_resid_mode: assert property (sTakeFrame ##0 !tcMode |=> !cmdResidenceUpdate)
    else $error("residence update outside transparent clock mode");

  a_cmd_hold: assert property (ce && !firstBeat && residPermit |=>
      $stable(cmdTsInsert) && $stable(offTimestamp) && $stable(cmdChecksumZero) &&
      $stable(offCorrection) && $stable(cmdResidenceUpdate))
    else $error("commands changed between frame starts");

  a_wb_ack: assert property (sBusReq |=> wb_ack_o ##1 (!wb_ack_o || !ce))
    else $error("bus answer not a single cycle after request");

endmodule : ptpo_out

// ---- testbench/ptpo_mac_model.sv ----
// Partner model: transmit-side inserter that latches the controls once per frame.
// Assumes frmSop/frmValid mark the first beat, delayed like the frame data.
`timescale 1ns/1ps
module ptpo_mac_model
  import ptpo_pkg::*;
(
  // Clock
  input wire logic core_clk,
  // First-beat markers from the stage
  input wire logic frmSop,
  input wire logic frmValid,
  // Commands and offsets from the stage
  input wire ptpo_decision_s ctl,
  // What the inserter latched for the current frame
  output ptpo_decision_s capt,
  output int unsigned seen
);
  // Start empty so a missed first beat shows up as zero controls
  initial begin
    capt = '0;
    seen = 0;
  end
  // Sample only at the first beat, as the editing logic does
  always @(posedge core_clk) begin
    if (frmSop === 1'b1 && frmValid === 1'b1) begin
      capt <= ctl;
      seen <= seen + 1;
    end
  end
endmodule : ptpo_mac_model

// ---- testbench/test_ptp_insert_control_outputs.sv ----
// Self-checking bench of the insertion-control output stage.
// Assumes the stage's registers answer one cycle after a taken request.
`timescale 1ns/1ps
`include "ptpo_map.svh"
module test_ptp_insert_control_outputs;
  import ptpo_pkg::*;
  logic core_clk, nrst, ce, wbCyc, wbStb, wbWe, wbAck, decValid, residPermit;
  logic frmSopIn, frmValidIn, frmEopIn, frmSop, frmValid, frmEop;
  logic [7:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [1:0] clockMode;
  ptpo_decision_s decIn, capt, d, e;
  wire ptpo_decision_s outCtl;
  int unsigned seen;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;

  // ----------------------------------------------------------------------
  // Clock, design and partner
  // ----------------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  ptpo_out #(.ADDR_W(8)) dut (.core_clk(core_clk), .nrst(nrst), .ce(ce),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .decValid(decValid),
    .decChecksumZero(decIn.checksumZero), .decChecksumCorrect(decIn.checksumCorrect),
    .decTsFormat(decIn.tsFormat), .decTsInsert(decIn.tsInsert),
    .decResidence(decIn.residence), .decOffTimestamp(decIn.offTimestamp),
    .decOffCorrection(decIn.offCorrection), .decOffChecksum(decIn.offChecksum),
    .decOffChecksumCorr(decIn.offChecksumCorr), .frmSopIn(frmSopIn),
    .frmValidIn(frmValidIn), .frmEopIn(frmEopIn), .frmSop(frmSop), .frmValid(frmValid),
    .frmEop(frmEop), .clockMode(clockMode), .residPermit(residPermit),
    .cmdChecksumZero(outCtl.checksumZero), .cmdChecksumCorrect(outCtl.checksumCorrect),
    .cmdTsFormat(outCtl.tsFormat), .cmdTsInsert(outCtl.tsInsert),
    .cmdResidenceUpdate(outCtl.residence), .offTimestamp(outCtl.offTimestamp),
    .offCorrection(outCtl.offCorrection), .offChecksum(outCtl.offChecksum),
    .offChecksumCorr(outCtl.offChecksumCorr));
  ptpo_mac_model mac (.core_clk(core_clk), .frmSop(frmSop), .frmValid(frmValid),
    .ctl(outCtl), .capt(capt), .seen(seen));

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [68:0] got, input logic [68:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  // One classic single cycle; held until ack is sampled high
  task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] wd,
                        output logic [31:0] r);
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDatI <= wd;
    @(posedge core_clk);
    while (wbAck !== 1'b1) @(posedge core_clk);
    r = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask : wbXfer

  // Optional decision, then a one-beat frame; returns once the partner latched it
  task automatic runFrame(input ptpo_decision_s dd, input logic give);
    @(posedge core_clk);
    if (give) begin
      decIn <= dd;
      decValid <= 1'b1;
      @(posedge core_clk);
      decValid <= 1'b0;
      @(posedge core_clk);
    end
    frmSopIn <= 1'b1;
    frmValidIn <= 1'b1;
    frmEopIn <= 1'b1;
    @(posedge core_clk);
    frmSopIn <= 1'b0;
    frmValidIn <= 1'b0;
    frmEopIn <= 1'b0;
    #1;
    check(69'({frmSop, frmValid, frmEop}), 69'({3{ce}}), "markers one cycle late");
    @(posedge core_clk);
    #1;
  endtask : runFrame

  // Residence only in transparent modes and with permission; offsets carry the bias
  function automatic ptpo_decision_s expOf(ptpo_decision_s x, logic [15:0] b,
                                           logic [1:0] m, logic p);
    ptpo_decision_s y;
    y = x;
    y.residence = x.residence & p & m[1];
    y.offTimestamp = x.offTimestamp + b;
    y.offCorrection = x.offCorrection + b;
    y.offChecksum = x.offChecksum + b;
    y.offChecksumCorr = x.offChecksumCorr + b;
    return y;
  endfunction : expOf

  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude

  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      conclude();
    end
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    nrst = 1'b0;
    {wbCyc, wbStb, wbWe, decValid, frmSopIn, frmValidIn, frmEopIn} = '0;
    {wbAdr, wbDatI, decIn, clockMode} = '0;
    wbSel = 4'hF;
    residPermit = 1'b1;
    ce = 1'b1;
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    #1;
    check(69'(outCtl), 69'(0), "outputs after reset");
    wbXfer(1'b0, `PTPO_ADR_CTRL, 32'h0, rd);
    check(69'(rd), 69'(1), "control reset value");
    wbXfer(1'b0, `PTPO_ADR_BIAS, 32'h0, rd);
    check(69'(rd), 69'(0), "bias reset value");
    wbXfer(1'b0, 8'h20, 32'h0, rd);
    check(69'(rd), 69'(0), "unmapped read");
    $display("test registers done");
    for (int k = 0; k < 8; k++) begin
      @(posedge core_clk);
      clockMode <= k[1:0];
      d = {5'(k * 7 + 3) | 5'h01, 16'(k * 256 + 1), 16'(k + 14), 16'(k + 40), 16'(k + 64)};
      runFrame(d, 1'b1);
      e = expOf(d, 16'h0000, k[1:0], 1'b1);
      check(capt, e, "commands at first beat");
      check(69'(seen), 69'(k + 1), "one latch per frame");
      wbXfer(1'b0, `PTPO_ADR_STATUS, 32'h0, rd);
      check(69'(rd[7:0]), 69'({2'b11 & {1'b1, e.residence}, e.tsInsert, 3'b000, k[1:0]}),
            "status mode and commands");
    end
    $display("test modes done");
    wbXfer(1'b1, `PTPO_ADR_BIAS, 32'h0000_0010, rd);
    d = {5'h1F, 16'hFFF8, 16'h0008, 16'h0028, 16'h002A};
    runFrame(d, 1'b1);
    e = expOf(d, 16'h0010, 2'b11, 1'b1);
    check(capt, e, "offsets with bias");
    @(posedge core_clk);
    residPermit <= 1'b0;
    repeat (2) @(posedge core_clk);
    #1;
    e.residence = 1'b0;
    check(outCtl, e, "permission low, others held");
    @(posedge core_clk);
    residPermit <= 1'b1;
    wbXfer(1'b0, `PTPO_ADR_FRAMES, 32'h0, rd);
    check(69'(rd), 69'(9), "accepted frames");
    // Clock enable low: a decision and a frame must leave every output frozen
    ce <= 1'b0;
    runFrame('0, 1'b1);
    check(outCtl, e, "outputs frozen while enable low");
    check(69'(seen), 69'(9), "no latch while frozen");
    @(posedge core_clk);
    ce <= 1'b1;
    $display("test bias and permission done");
    runFrame(d, 1'b0);
    check(capt, 69'(0), "frame without decision");
    wbXfer(1'b0, `PTPO_ADR_MISSES, 32'h0, rd);
    check(69'(rd), 69'(1), "missed first beats");
    wbXfer(1'b1, `PTPO_ADR_CTRL, 32'h0, rd);
    runFrame(d, 1'b1);
    check(capt, 69'(0), "frame while disabled");
    // Two loads before a frame raise overrun; write-one clears the sticky flags
    @(posedge core_clk);
    decValid <= 1'b1;
    repeat (2) @(posedge core_clk);
    decValid <= 1'b0;
    wbXfer(1'b0, `PTPO_ADR_STATUS, 32'h0, rd);
    check(69'(rd[4:2]), 69'(3'b111), "miss, overrun and pending flags");
    wbXfer(1'b1, `PTPO_ADR_STATUS, 32'h0000_0018, rd);
    wbXfer(1'b0, `PTPO_ADR_STATUS, 32'h0, rd);
    check(69'(rd[4:2]), 69'(3'b001), "flags cleared, decision kept");
    $display("test refusals done");
    conclude();
  end
endmodule : test_ptp_insert_control_outputs
